// ==== src/imc_pkg.sv ====
/*
  constants and types for the input mux and mode control block.
  assumes a single 10 MHz clock and a synchronous active-low reset.
*/
// Operation
// - both pairs present: driver one on by default
// - all drivers off bit forces both off
// - host may swap active input when both valid
// - high impedance request forces both drivers off
// - drive only present inputs; input one preferred
// - report both pairs present when detected
// - reverse power entry write sets all drivers off
// - overvoltage in reverse power drops drivers and charge, keeps reverse power
// - watchdog expiry clears reverse power enable
// - bypass and charge turn on bypass switches
// - fault in bypass clears charge only
// - driver turns on only when all conditions hold
// - at reset grounded driver pin means pair absent
package imc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DRIVE = 4'h1;
  localparam logic [3:0] REG_STAT = 4'h2;
  localparam logic [3:0] REG_PULL = 4'h3;
  // control register fields
  localparam int CTRL_ALL_OFF = 0;
  localparam int CTRL_HIZ = 1;
  localparam int CTRL_REV = 2;
  localparam int CTRL_CHG = 3;
  localparam int CTRL_BYP = 4;
  // drive register fields
  localparam int DRV_ONE = 0;
  localparam int DRV_TWO = 1;
  // status register fields
  localparam int ST_PAIR_ONE = 0;
  localparam int ST_PAIR_TWO = 1;
  localparam int ST_BYPASS_ON = 2;
  localparam int ST_CONV_ON = 3;
  // pulldown register fields
  localparam int PD_RAIL = 0;
  localparam int PD_ONE = 1;
  localparam int PD_TWO = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  // strap sampling time after reset release
  localparam int STRAP_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int STRAP_CYC = (STRAP_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {SEL_NONE, SEL_ONE, SEL_TWO} imc_sel_t;
endpackage

// ==== src/imc_cond_if.sv ====
/*
  interface carrying the synchronised analog conditions between the
  input front end and the control core.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface imc_cond_if;
  logic in_one_ok;
  logic in_two_ok;
  logic rail_low;
  logic ovp_fault;
  logic any_fault;
  logic wdog_expired;
  modport src (output in_one_ok, in_two_ok, rail_low, ovp_fault, any_fault, wdog_expired);
  modport dst (input in_one_ok, in_two_ok, rail_low, ovp_fault, any_fault, wdog_expired);
endinterface

// ==== src/imc_sync.sv ====
/*
  two flip-flop synchroniser bank for the analog comparator inputs,
  feeding combined condition levels to the core.
  assumes inputs are asynchronous levels.
*/
`timescale 1ns/1ps
module imc_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] raw_in,
  imc_cond_if.src cond
);
  import imc_pkg::*;
  logic [7:0] s1_q, s1_d, s2_q, s2_d;
  // next values of both stages
  always_comb begin
    s1_d = raw_in;
    s2_d = s1_q;
  end
  // register stages
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  // raw bits: 0 in1 present, 1 in1 ovp, 2 in2 present, 3 in2 ovp,
  // 4 rail present, 5 rail ovp, 6 other fault, 7 watchdog expired
  assign cond.in_one_ok = s2_q[0] & ~s2_q[1];
  assign cond.in_two_ok = s2_q[2] & ~s2_q[3];
  assign cond.rail_low = ~s2_q[4];
  assign cond.ovp_fault = s2_q[1] | s2_q[3] | s2_q[5];
  assign cond.any_fault = s2_q[1] | s2_q[3] | s2_q[5] | s2_q[6];
  assign cond.wdog_expired = s2_q[7];
endmodule // imc_sync

// ==== src/imc_top.sv ====
/*
  input mux and mode control: gate driver selection, reverse power
  entry and fault handling, bypass mode switch control, host registers.
  assumes host register port on the same clock; pins sampled twice.
*/
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module imc_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [imc_pkg::ADDR_W-1:0] addr,
  input wire logic [imc_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [imc_pkg::DATA_W-1:0] rdata,
  input wire logic adapter_input_one_present,
  input wire logic adapter_input_one_ovp,
  input wire logic adapter_input_two_present,
  input wire logic adapter_input_two_ovp,
  input wire logic converter_input_rail_present,
  input wire logic rail_overvoltage_fault,
  input wire logic other_fault,
  input wire logic watchdog_expired,
  input wire logic drv_one_grounded,
  input wire logic drv_two_grounded,
  output logic gate_driver_one,
  output logic gate_driver_two,
  output logic bypass_switches_on,
  output logic converter_run,
  output logic rail_pulldown_enable,
  output logic input_one_pulldown_enable,
  output logic input_two_pulldown_enable
);
  import imc_pkg::*;

  imc_cond_if cond ();
  logic [1:0] strap_s1_q, strap_s2_q;

  // synchronise condition pins
  imc_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .raw_in({watchdog_expired, other_fault, rail_overvoltage_fault,
             converter_input_rail_present, adapter_input_two_ovp,
             adapter_input_two_present, adapter_input_one_ovp,
             adapter_input_one_present}),
    .cond(cond)
  );

  // strap pins through two flops before use
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_s1_q <= 2'b00;
      strap_s2_q <= 2'b00;
    end else begin
      strap_s1_q <= {drv_two_grounded, drv_one_grounded};
      strap_s2_q <= strap_s1_q;
    end
  end

  // ---- population detection after reset release
  logic [3:0] strap_cnt_q, strap_cnt_d;
  logic pair_one_q, pair_one_d, pair_two_q, pair_two_d;
  logic strap_done_q, strap_done_d;

  // wait STRAP_CYC then latch the grounded test once
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    strap_done_d = strap_done_q;
    pair_one_d = pair_one_q;
    pair_two_d = pair_two_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == 4'(STRAP_CYC)) begin
        strap_done_d = 1'b1;
        pair_one_d = ~strap_s2_q[0];
        pair_two_d = ~strap_s2_q[1];
      end else begin
        strap_cnt_d = strap_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_cnt_q <= 4'h0;
      strap_done_q <= 1'b0;
      pair_one_q <= 1'b0;
      pair_two_q <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      pair_one_q <= pair_one_d;
      pair_two_q <= pair_two_d;
    end
  end

  // ---- control registers
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] pull_q, pull_d;
  imc_sel_t sel_q, sel_d;
  logic ovp_q, ovp_d;
  logic fault_q, fault_d;
  logic wr_ctrl, wr_drive, wr_pull;
  logic permit_one, permit_two, both_dual;

  assign wr_ctrl = wr_en && addr == REG_CTRL;
  assign wr_drive = wr_en && addr == REG_DRIVE;
  assign wr_pull = wr_en && addr == REG_PULL;
  assign both_dual = pair_one_q & pair_two_q;

  // per-port turn-on permission
  always_comb begin
    permit_one = pair_one_q & cond.in_one_ok & ~ctrl_q[CTRL_ALL_OFF]
                 & ~ctrl_q[CTRL_HIZ] & cond.rail_low;
    permit_two = pair_two_q & cond.in_two_ok & ~ctrl_q[CTRL_ALL_OFF]
                 & ~ctrl_q[CTRL_HIZ] & cond.rail_low;
  end

  // control register next state with hardware overrides
  always_comb begin
    ctrl_d = ctrl_q;
    pull_d = pull_q;
    ovp_d = cond.ovp_fault;
    fault_d = cond.any_fault;
    if (wr_ctrl) begin
      ctrl_d = {3'b000, wdata[4:0]};
      if (wdata[CTRL_REV] && !ctrl_q[CTRL_REV]) begin
        ctrl_d[CTRL_ALL_OFF] = 1'b1;
      end
    end
    if (wr_pull) begin
      pull_d = {5'b00000, wdata[2:0]};
    end
    // rising fault: charge dropped, bypass kept
    if (cond.any_fault && !fault_q) begin
      ctrl_d[CTRL_CHG] = 1'b0;
    end
    if (cond.wdog_expired) begin
      ctrl_d[CTRL_REV] = 1'b0;
      ctrl_d[CTRL_CHG] = 1'b0;
    end
  end

  // driver selection: default input one, host swap, forced off
  always_comb begin
    sel_d = sel_q;
    if (wr_drive) begin
      if (wdata[DRV_ONE]) begin
        sel_d = SEL_ONE;
      end else if (wdata[DRV_TWO]) begin
        sel_d = SEL_TWO;
      end else begin
        sel_d = SEL_NONE;
      end
    end else if (!ctrl_q[CTRL_REV] && sel_q == SEL_NONE) begin
      // automatic choice outside reverse power
      if (permit_one) begin
        sel_d = SEL_ONE;
      end else if (permit_two && !cond.in_one_ok) begin
        sel_d = SEL_TWO;
      end
    end
    // active port lost: clear so state matches hardware
    case (sel_d)
      SEL_ONE: if (!permit_one) sel_d = SEL_NONE;
      SEL_TWO: if (!permit_two) sel_d = SEL_NONE;
      default: sel_d = SEL_NONE;
    endcase
    if (ctrl_q[CTRL_REV] && cond.ovp_fault) begin
      sel_d = SEL_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      pull_q <= PULL_RST;
      sel_q <= SEL_NONE;
      ovp_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      pull_q <= pull_d;
      sel_q <= sel_d;
      ovp_q <= ovp_d;
      fault_q <= fault_d;
    end
  end

  // ---- registered outputs
  logic drv1_d, drv2_d, byp_d, conv_d;
  logic [7:0] rdata_d;

  // output drive and read mux
  always_comb begin
    drv1_d = sel_d == SEL_ONE;
    drv2_d = sel_d == SEL_TWO;
    byp_d = ctrl_d[CTRL_BYP] & ctrl_d[CTRL_CHG];
    conv_d = ~ctrl_d[CTRL_BYP] & ctrl_d[CTRL_CHG];
    rdata_d = 8'h00;
    if (rd_en) begin
      case (addr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_DRIVE: rdata_d = {6'b000000, gate_driver_two, gate_driver_one};
        REG_STAT: rdata_d = {4'h0, converter_run, bypass_switches_on,
                             pair_two_q, pair_one_q};
        REG_PULL: rdata_d = pull_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gate_driver_one <= 1'b0;
      gate_driver_two <= 1'b0;
      bypass_switches_on <= 1'b0;
      converter_run <= 1'b0;
      rail_pulldown_enable <= 1'b0;
      input_one_pulldown_enable <= 1'b0;
      input_two_pulldown_enable <= 1'b0;
      rdata <= 8'h00;
    end else begin
      gate_driver_one <= drv1_d;
      gate_driver_two <= drv2_d;
      bypass_switches_on <= byp_d;
      converter_run <= conv_d;
      rail_pulldown_enable <= pull_d[PD_RAIL];
      input_one_pulldown_enable <= pull_d[PD_ONE];
      input_two_pulldown_enable <= pull_d[PD_TWO];
      rdata <= rdata_d;
    end
  end

  // ---- checks
  chk_one_hot_drv: assert property (@(posedge clock) disable iff (!rst_n)
    !(gate_driver_one && gate_driver_two))
    else $error("both gate drivers on");
  chk_alloff_kills: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_q[CTRL_ALL_OFF] |=> !gate_driver_one && !gate_driver_two)
    else $error("drivers on while all off set");
  chk_hiz_kills: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_q[CTRL_HIZ] |=> !gate_driver_one && !gate_driver_two)
    else $error("drivers on while high impedance");
  chk_rev_sets_off: assert property (@(posedge clock) disable iff (!rst_n)
    wr_ctrl && wdata[CTRL_REV] && !ctrl_q[CTRL_REV] |=> ctrl_q[CTRL_ALL_OFF])
    else $error("reverse entry did not set all off");
  chk_wdog_clears: assert property (@(posedge clock) disable iff (!rst_n)
    cond.wdog_expired |=> !ctrl_q[CTRL_REV])
    else $error("watchdog left reverse power on");
  chk_rev_ovp_drop: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_q[CTRL_REV] && cond.ovp_fault && !cond.wdog_expired && !wr_ctrl
    |=> !gate_driver_one && !gate_driver_two && ctrl_q[CTRL_REV])
    else $error("reverse ovp handling wrong");
  chk_bypass_fault: assert property (@(posedge clock) disable iff (!rst_n)
    cond.any_fault && !fault_q && ctrl_q[CTRL_BYP] && !wr_ctrl
    |=> !ctrl_q[CTRL_CHG] && ctrl_q[CTRL_BYP])
    else $error("bypass fault handling wrong");
  chk_drv_permit: assert property (@(posedge clock) disable iff (!rst_n)
    gate_driver_one |-> $past(permit_one))
    else $error("driver one on without permission");
  chk_bypass_out: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_q[CTRL_BYP] && ctrl_q[CTRL_CHG] |-> bypass_switches_on)
    else $error("bypass switches not on");
  cov_default_one: cover property (@(posedge clock) disable iff (!rst_n)
    both_dual && !gate_driver_one ##1 gate_driver_one);
  cov_swap_two: cover property (@(posedge clock) disable iff (!rst_n)
    gate_driver_one ##1 gate_driver_two);
  cov_rev_entry: cover property (@(posedge clock) disable iff (!rst_n)
    wr_ctrl && wdata[CTRL_REV] ##1 ctrl_q[CTRL_ALL_OFF]);
  cov_bypass: cover property (@(posedge clock) disable iff (!rst_n)
    bypass_switches_on);
endmodule // imc_top

// ==== verification/imc_supply_model.sv ====
/*
  supply side partner: two adapter sources, fet pair straps and rail.
  assumes the bench sets the source levels; both fet pairs are fitted.
*/
`timescale 1ns/1ps
module imc_supply_model (
  input wire logic src_one_on,
  input wire logic src_two_on,
  input wire logic surge,
  input wire logic rail_charge,
  output logic adapter_input_one_present,
  output logic adapter_input_one_ovp,
  output logic adapter_input_two_present,
  output logic adapter_input_two_ovp,
  output logic converter_input_rail_present,
  output logic drv_one_grounded,
  output logic drv_two_grounded
);
  // both pairs fitted, so no driver pin is strapped to ground
  assign drv_one_grounded = 1'b0;
  assign drv_two_grounded = 1'b0;
  // sources land on the two inputs only; the rail sees leftover charge alone
  assign converter_input_rail_present = rail_charge;
  assign adapter_input_one_present = src_one_on;
  assign adapter_input_two_present = src_two_on;
  // one shared overvoltage level, so a surge trips every input whose source is on
  assign adapter_input_one_ovp = src_one_on & surge;
  assign adapter_input_two_ovp = src_two_on & surge;
endmodule // imc_supply_model

// ==== verification/imc_top_bench.sv ====
/*
  self-checking bench for the input mux and mode control block.
  assumes the supply model on the far side and a 10 MHz clock.
*/
`timescale 1ns/1ps
module imc_top_bench;
  import imc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic s1 = 1'b1, s2 = 1'b1, surge = 1'b0, rail_charge = 1'b0;
  logic rail_ovp = 1'b0, other_fault = 1'b0, wdog = 1'b0;
  logic a1p, a1o, a2p, a2o, railp, g1, g2;
  logic gate_driver_one, gate_driver_two, byp_on, conv_run, pd_r, pd_1, pd_2;
  int fails = 0;
  int comparisons = 0;
  int seed = 32'hc94ad2a8;
  logic [3:0] ra;
  logic [7:0] rv;

  imc_supply_model far (.src_one_on(s1), .src_two_on(s2), .surge(surge),
    .rail_charge(rail_charge), .adapter_input_one_present(a1p), .adapter_input_one_ovp(a1o),
    .adapter_input_two_present(a2p), .adapter_input_two_ovp(a2o),
    .converter_input_rail_present(railp), .drv_one_grounded(g1), .drv_two_grounded(g2));

  imc_top uut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .adapter_input_one_present(a1p),
    .adapter_input_one_ovp(a1o), .adapter_input_two_present(a2p),
    .adapter_input_two_ovp(a2o), .converter_input_rail_present(railp),
    .rail_overvoltage_fault(rail_ovp), .other_fault(other_fault),
    .watchdog_expired(wdog), .drv_one_grounded(g1), .drv_two_grounded(g2),
    .gate_driver_one(gate_driver_one), .gate_driver_two(gate_driver_two),
    .bypass_switches_on(byp_on), .converter_run(conv_run), .rail_pulldown_enable(pd_r),
    .input_one_pulldown_enable(pd_1), .input_two_pulldown_enable(pd_2));

  // free running clock, 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end

  task automatic conclude();
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one write cycle, strobe high for exactly one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // read strobe for one edge, data taken in the following cycle only
  task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check(name, rdata, exp);
    // return on a rising edge so the caller's next drive lands on it
    @(posedge clock);
  endtask

  // bounded wait for the driver pair, then hold a few edges to catch late changes
  task automatic gates(input string name, input logic [1:0] exp);
    int n;
    n = 0;
    while ({gate_driver_two, gate_driver_one} !== exp && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    repeat (4) @(posedge clock);
    #1;
    if (n >= 40) begin
      fails++;
      conclude();
    end else begin
      check(name, {6'h00, gate_driver_two, gate_driver_one}, {6'h00, exp});
    end
    // return on a rising edge so the caller's next drive lands on it
    @(posedge clock);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rchk("ctrl reset", REG_CTRL, CTRL_RST);
    rchk("pull reset", REG_PULL, PULL_RST);
    gates("default port", 2'b01);
    rchk("pairs present", REG_STAT, 8'h03);
    rchk("drive default", REG_DRIVE, 8'h01);
    wr(REG_DRIVE, 8'h02);
    gates("swap to two", 2'b10);
    rchk("drive two", REG_DRIVE, 8'h02);
    wr(REG_DRIVE, 8'h03);
    gates("both asked", 2'b01);
    wr(REG_CTRL, 8'h01);
    gates("all off", 2'b00);
    rchk("drive all off", REG_DRIVE, 8'h00);
    rail_charge <= 1'b1;
    wr(REG_CTRL, 8'h00);
    gates("rail busy", 2'b00);
    rail_charge <= 1'b0;
    gates("rail clear", 2'b01);
    wr(REG_CTRL, 8'h02);
    gates("hiz", 2'b00);
    wr(REG_CTRL, 8'h00);
    s1 <= 1'b0;
    gates("one absent", 2'b10);
    surge <= 1'b1;
    gates("surge", 2'b00);
    surge <= 1'b0;
    s1 <= 1'b1;
    gates("both back", 2'b01);
    // reverse power entry, fault and exit
    wr(REG_CTRL, 8'h04);
    rchk("reverse entry", REG_CTRL, 8'h05);
    gates("reverse entry off", 2'b00);
    wr(REG_CTRL, 8'h04);
    gates("no auto pick", 2'b00);
    wr(REG_DRIVE, 8'h02);
    gates("reverse port", 2'b10);
    rail_ovp <= 1'b1;
    gates("reverse fault", 2'b00);
    rchk("reverse kept", REG_CTRL, 8'h04);
    rchk("drive fault", REG_DRIVE, 8'h00);
    rail_ovp <= 1'b0;
    gates("fault cleared", 2'b00);
    wr(REG_DRIVE, 8'h02);
    gates("port rewritten", 2'b10);
    wr(REG_PULL, 8'h01);
    rchk("pulldown set", REG_PULL, 8'h01);
    check("rail pulldown", {7'h00, pd_r}, 8'h01);
    wr(REG_DRIVE, 8'h00);
    gates("exit port off", 2'b00);
    wr(REG_CTRL, 8'h00);
    rchk("exit reverse", REG_CTRL, 8'h00);
    wr(REG_PULL, 8'h00);
    gates("after reverse", 2'b01);
    wr(REG_CTRL, 8'h04);
    wdog <= 1'b1;
    repeat (4) @(posedge clock);
    wdog <= 1'b0;
    rchk("watchdog", REG_CTRL, 8'h01);
    wr(REG_CTRL, 8'h00);
    // bypass mode, fault in bypass, mode change
    wr(REG_CTRL, 8'h18);
    rchk("bypass stat", REG_STAT, 8'h07);
    check("bypass on", {7'h00, byp_on}, 8'h01);
    other_fault <= 1'b1;
    repeat (4) @(posedge clock);
    other_fault <= 1'b0;
    rchk("bypass fault", REG_CTRL, 8'h10);
    check("bypass dropped", {7'h00, byp_on}, 8'h00);
    wr(REG_CTRL, 8'h00);
    wr(REG_CTRL, 8'h08);
    rchk("switched cap", REG_STAT, 8'h0B);
    check("converter run", {7'h00, conv_run}, 8'h01);
    wr(REG_CTRL, 8'h00);
    // random unmapped accesses and pulldown patterns
    for (int i = 0; i < 16; i++) begin
      ra = 4'h4 + 4'($unsigned($random(seed)) % 12);
      wr(ra, 8'($random(seed)));
      rchk("unmapped", ra, 8'h00);
      rv = {5'h00, 3'($random(seed))};
      wr(REG_PULL, rv);
      rchk("pull readback", REG_PULL, rv);
      check("pulldowns", {5'h00, pd_2, pd_1, pd_r}, rv);
    end
    conclude();
  end
endmodule // imc_top_bench
